/* File: rtl/hrs_params.svh */
// hrs_params.svh: register offsets, fields, reset values and timing for home return sequencer
// assumes: included by the design module and the bench; APB byte addresses
`ifndef HRS_PARAMS_SVH
`define HRS_PARAMS_SVH
// ==================================================
// register byte offsets
`define HRS_OFF_CTRL 12'h000
`define HRS_OFF_CFG 12'h004
`define HRS_OFF_HOME_ADDR 12'h008
`define HRS_OFF_STBY_ADDR 12'h00C
`define HRS_OFF_HR_SPEED 12'h010
`define HRS_OFF_CREEP 12'h014
`define HRS_OFF_ACC_TIME 12'h018
`define HRS_OFF_DSTOP_TIME 12'h01C
`define HRS_OFF_POST_DOG 12'h020
`define HRS_OFF_DWELL 12'h024
`define HRS_OFF_STATUS 12'h028
`define HRS_OFF_FEED_POS 12'h02C
`define HRS_OFF_CUR_SPEED 12'h030
// ==================================================
// field positions
`define HRS_CTRL_START 0
`define HRS_CTRL_TYPE_LO 1
`define HRS_CFG_METHOD_LO 0
`define HRS_CFG_DIR 4
`define HRS_ST_BUSY 0
`define HRS_ST_DONE 1
`define HRS_ST_REQ 2
`define HRS_ST_ERR 3
// ==================================================
// reset values
`define HRS_RST_ACC_TIME 16'h03E8
`define HRS_RST_DSTOP_TIME 16'h03E8
`define HRS_RST_SPEED 18'h0_0001
`define HRS_RST_DWELL 16'h0000
`define HRS_MAX_MS 16'h7FFF
`define HRS_MAX_POST_DOG 32'h7FFF_FFFF
// ==================================================
// timing
`define HRS_CLK_HZ 40000000
`define HRS_MS_NS 1000000
`define HRS_CLK_NS 25
`define HRS_CYC_PER_MS (`HRS_MS_NS / `HRS_CLK_NS)
`endif

/* File: rtl/hrs_pkg.sv */
// hrs_pkg: types for the home return sequencer
// assumes: the params header is present on the include path
package hrs_pkg;
  // ==================================================
  // methods, return types, states
  typedef enum logic [2:0] {
    HRS_M_DOG = 3'h0,
    HRS_M_STOP1 = 3'h1,
    HRS_M_STOP2 = 3'h2,
    HRS_M_STOP3 = 3'h3,
    HRS_M_CNT1 = 3'h4,
    HRS_M_CNT2 = 3'h5
  } hrs_method_t;
  typedef enum logic [1:0] {
    HRS_T_MACHINE = 2'h0,
    HRS_T_FAST_HOME = 2'h1,
    HRS_T_FAST_STBY = 2'h2
  } hrs_type_t;
  typedef enum logic [2:0] {
    HRS_S_IDLE = 3'b000,
    HRS_S_FAST = 3'b001,
    HRS_S_SEEK = 3'b011,
    HRS_S_CREEP = 3'b010,
    HRS_S_TRAVEL = 3'b110,
    HRS_S_ZERO = 3'b111,
    HRS_S_DONE = 3'b101
  } hrs_state_t;
  // pulse outputs toward the drive
  typedef struct packed {
    logic step;
    logic dir;
  } hrs_drive_t;
  // sensors from the axis
  typedef struct packed {
    logic dog;
    logic zero;
  } hrs_sense_t;
endpackage : hrs_pkg

/* File: rtl/hrs_home_return_sequencer.sv */
// hrs_home_return_sequencer: home return control for one pulse-output axis group
// assumes: APB master on pclk, dog and zero sensors asynchronous, drive takes step/dir
// Functional notes
// - machine and fast home return both offered
// - machine return starts only by start command
// - fast return targets home or standby address
// - home request flagged after reset
// - fast return refused before home established
// - one parameter set shared by all axes
// - method affects machine return only
// - speed until dog, then creep speed
// - dog method stops at zero after dog off
// - stopper 1 stops after dwell from dog
// - stopper 2 stops on zero after creep
// - stopper 3 creeps from start, zero stops
// - count 1 travels distance then zero stops
// - count 2 travels distance, decelerates, stops
// - accel time 0..32767 ms, reset 1000
// - separate decel-stop time, max 32767 ms
// - post-dog distance 0..2147483647, reset 0
// - dwell used only by stopper 1 here
// - direction bit sets address sign
// - feed position set to home address after machine return
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "hrs_params.svh"
module hrs_home_return_sequencer
  import hrs_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = `HRS_CYC_PER_MS,
  parameter int unsigned CLK_HZ = `HRS_CLK_HZ
)(
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // axis
  input wire hrs_sense_t sense,
  output hrs_drive_t drive
);
  // ==================================================
  // bus decode
  wire wr_en = psel && penable && pwrite && clk_en;
  wire rd_en = psel && penable && !pwrite;
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction : hit
  wire mapped = paddr <= `HRS_OFF_CUR_SPEED && paddr[1:0] == 2'b00;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ==================================================
  // shared configuration, one set for all axes
  logic [2:0] method_r;
  logic dir_r;
  logic [31:0] home_addr_r, stby_addr_r, post_dog_r;
  logic [17:0] hr_speed_r, creep_r;
  logic [15:0] acc_time_r, dstop_time_r, dwell_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      method_r <= HRS_M_DOG;
      dir_r <= 1'b0;
      home_addr_r <= 32'h0000_0000;
      stby_addr_r <= 32'h0000_0000;
      post_dog_r <= 32'h0000_0000;
      hr_speed_r <= `HRS_RST_SPEED;
      creep_r <= `HRS_RST_SPEED;
      acc_time_r <= `HRS_RST_ACC_TIME;
      dstop_time_r <= `HRS_RST_DSTOP_TIME;
      dwell_r <= `HRS_RST_DWELL;
    end
    else if (wr_en)
    begin
      if (hit(paddr, `HRS_OFF_CFG))
      begin
        method_r <= pwdata[2:0];
        dir_r <= pwdata[`HRS_CFG_DIR];
      end
      if (hit(paddr, `HRS_OFF_HOME_ADDR)) home_addr_r <= pwdata;
      if (hit(paddr, `HRS_OFF_STBY_ADDR)) stby_addr_r <= pwdata;
      if (hit(paddr, `HRS_OFF_HR_SPEED)) hr_speed_r <= pwdata[17:0];
      if (hit(paddr, `HRS_OFF_CREEP)) creep_r <= pwdata[17:0];
      if (hit(paddr, `HRS_OFF_ACC_TIME)) acc_time_r <= pwdata[15] ? `HRS_MAX_MS : pwdata[15:0];
      if (hit(paddr, `HRS_OFF_DSTOP_TIME)) dstop_time_r <= pwdata[15] ? `HRS_MAX_MS : pwdata[15:0];
      if (hit(paddr, `HRS_OFF_POST_DOG)) post_dog_r <= {1'b0, pwdata[30:0]};
      if (hit(paddr, `HRS_OFF_DWELL)) dwell_r <= pwdata[15:0];
    end
  end

  // ==================================================
  // sensor synchronisers: first stage feeds only the second
  logic [1:0] dog_s_r, zero_s_r;
  logic dog_q_r, zero_q_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dog_s_r <= 2'b00;
      zero_s_r <= 2'b00;
      dog_q_r <= 1'b0;
      zero_q_r <= 1'b0;
    end
    else if (clk_en)
    begin
      dog_s_r <= {dog_s_r[0], sense.dog};
      zero_s_r <= {zero_s_r[0], sense.zero};
      dog_q_r <= dog_s_r[1];
      zero_q_r <= zero_s_r[1];
    end
  end
  wire dog = dog_s_r[1];
  wire dog_rise = dog_s_r[1] && !dog_q_r;
  wire dog_fall = !dog_s_r[1] && dog_q_r;
  wire zero_rise = zero_s_r[1] && !zero_q_r;

  // ==================================================
  // start command decode
  wire start_cmd = wr_en && hit(paddr, `HRS_OFF_CTRL) && pwdata[`HRS_CTRL_START];
  wire [1:0] start_type = pwdata[`HRS_CTRL_TYPE_LO +: 2];

  // ==================================================
  // sequencer state
  hrs_state_t state_r, state_nxt;
  logic busy_r, done_r, req_r, err_r;
  logic fast_r, fdir_r, dogoff_r;
  logic [31:0] feed_r, target_r, travel_r, dwell_cnt_r;
  logic [17:0] speed_r, speed_tgt;
  logic [31:0] ms_cnt_r, ramp_cnt_r;
  logic step_tick;

  // fast return is legal only once home is established
  wire fast_ok = done_r;
  wire go_mach = start_cmd && !busy_r && start_type == HRS_T_MACHINE;
  wire go_fast = start_cmd && !busy_r && fast_ok
    && (start_type == HRS_T_FAST_HOME || start_type == HRS_T_FAST_STBY);
  wire bad_start = start_cmd && !busy_r && !go_mach && !go_fast;
  wire at_target = feed_r == target_r;
  wire travel_done = travel_r == 32'h0000_0000;
  wire dwell_done = dwell_cnt_r >= {16'h0000, dwell_r};
  // count 2 slows to a floor, not to zero, so the set distance always completes
  wire [17:0] stop_floor = (creep_r >> 2) + 18'h0_0001;

  // next-state logic; method ignored in fast mode
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      HRS_S_IDLE:
      begin
        if (go_fast) state_nxt = HRS_S_FAST;
        else if (go_mach) state_nxt = (method_r == HRS_M_STOP3) ? HRS_S_CREEP : HRS_S_SEEK;
      end
      HRS_S_FAST: if (at_target) state_nxt = HRS_S_DONE;
      HRS_S_SEEK: if (dog_rise || dog) state_nxt = HRS_S_CREEP;
      HRS_S_CREEP:
      begin
        case (method_r)
          HRS_M_DOG: if (dogoff_r && zero_rise) state_nxt = HRS_S_DONE;
          HRS_M_STOP1: if (dwell_done) state_nxt = HRS_S_DONE;
          HRS_M_STOP2, HRS_M_STOP3: if (zero_rise) state_nxt = HRS_S_DONE;
          HRS_M_CNT1, HRS_M_CNT2: state_nxt = HRS_S_TRAVEL;
          default: state_nxt = HRS_S_DONE;
        endcase
      end
      HRS_S_TRAVEL:
      begin
        if (travel_done) state_nxt = (method_r == HRS_M_CNT1) ? HRS_S_ZERO : HRS_S_DONE;
      end
      HRS_S_ZERO: if (zero_rise) state_nxt = HRS_S_DONE;
      HRS_S_DONE: state_nxt = HRS_S_IDLE;
      default: state_nxt = HRS_S_IDLE;
    endcase
  end

  // target speed per state
  always_comb
  begin
    speed_tgt = 18'h0_0000;
    case (state_r)
      HRS_S_FAST, HRS_S_SEEK: speed_tgt = hr_speed_r;
      HRS_S_CREEP, HRS_S_ZERO: speed_tgt = creep_r;
      HRS_S_TRAVEL: speed_tgt = (method_r == HRS_M_CNT2) ? stop_floor : creep_r;
      default: speed_tgt = 18'h0_0000;
    endcase
  end

  // ramp step: one unit per tick of the ramp timer, time from the active setting
  wire [15:0] ramp_ms = (state_r == HRS_S_TRAVEL && method_r == HRS_M_CNT2) ? dstop_time_r : acc_time_r;
  wire [17:0] ramp_base = (hr_speed_r == 18'h0_0000) ? 18'h0_0001 : hr_speed_r;
  wire [31:0] ramp_div = (32'(ramp_ms) * 32'(CYC_PER_MS)) / 32'(ramp_base);
  wire ramp_tick = ramp_cnt_r >= ramp_div;
  // millisecond timer kept apart from the ramp timer so neither cuts the other short
  wire ms_tick = ms_cnt_r == 32'(CYC_PER_MS - 1);

  // ==================================================
  // sequencer registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= HRS_S_IDLE;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      req_r <= 1'b1;
      err_r <= 1'b0;
      fast_r <= 1'b0;
      fdir_r <= 1'b0;
      dogoff_r <= 1'b0;
      feed_r <= 32'h0000_0000;
      target_r <= 32'h0000_0000;
      travel_r <= 32'h0000_0000;
      dwell_cnt_r <= 32'h0000_0000;
      speed_r <= 18'h0_0000;
      ms_cnt_r <= 32'h0000_0000;
      ramp_cnt_r <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      state_r <= state_nxt;
      if (bad_start) err_r <= 1'b1;
      else if (go_mach || go_fast) err_r <= 1'b0;
      if (go_mach)
      begin
        busy_r <= 1'b1;
        done_r <= 1'b0;
        fast_r <= 1'b0;
        fdir_r <= dir_r;
        dogoff_r <= 1'b0;
        dwell_cnt_r <= 32'h0000_0000;
      end
      if (go_fast)
      begin
        busy_r <= 1'b1;
        fast_r <= 1'b1;
        target_r <= (start_type == HRS_T_FAST_HOME) ? home_addr_r : stby_addr_r;
        fdir_r <= (start_type == HRS_T_FAST_HOME) ? ($signed(home_addr_r) > $signed(feed_r))
          : ($signed(stby_addr_r) > $signed(feed_r));
      end
      if (state_r == HRS_S_SEEK && state_nxt == HRS_S_CREEP) travel_r <= post_dog_r;
      if (dog_fall && state_r == HRS_S_CREEP) dogoff_r <= 1'b1;
      // dwell counted in ms from dog on
      if (busy_r && !fast_r && state_r != HRS_S_SEEK && ms_tick)
        dwell_cnt_r <= dwell_cnt_r + 32'h0000_0001;
      if (ms_tick) ms_cnt_r <= 32'h0000_0000;
      else ms_cnt_r <= ms_cnt_r + 32'h0000_0001;
      if (ramp_tick) ramp_cnt_r <= 32'h0000_0000;
      else ramp_cnt_r <= ramp_cnt_r + 32'h0000_0001;
      // linear ramp toward target speed
      if (ramp_tick && speed_r < speed_tgt) speed_r <= speed_r + 18'h0_0001;
      else if (ramp_tick && speed_r > speed_tgt) speed_r <= speed_r - 18'h0_0001;
      if (state_nxt == HRS_S_DONE || state_nxt == HRS_S_IDLE) speed_r <= 18'h0_0000;
      if (step_tick)
      begin
        feed_r <= fdir_r ? feed_r + 32'h0000_0001 : feed_r - 32'h0000_0001;
        if (state_r == HRS_S_TRAVEL && !travel_done) travel_r <= travel_r - 32'h0000_0001;
      end
      if (state_r == HRS_S_DONE)
      begin
        busy_r <= 1'b0;
        if (!fast_r)
        begin
          feed_r <= home_addr_r;
          done_r <= 1'b1;
          req_r <= 1'b0;
        end
      end
    end
  end

  // ==================================================
  // pulse generator: phase accumulator at the current speed
  logic [31:0] phase_r;
  logic step_r;
  wire [32:0] phase_sum = {1'b0, phase_r} + 33'(speed_r);
  wire pulse_ok = busy_r && state_r != HRS_S_DONE && !(fast_r && at_target);
  assign step_tick = pulse_ok && phase_sum >= 33'(CLK_HZ);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_r <= 32'h0000_0000;
      step_r <= 1'b0;
    end
    else if (clk_en)
    begin
      phase_r <= !pulse_ok ? 32'h0000_0000 : step_tick ? 32'(phase_sum - 33'(CLK_HZ)) : phase_sum[31:0];
      step_r <= step_tick;
    end
  end
  // step gated by the enable so a frozen block never repeats a pulse
  assign drive = '{step: step_r && clk_en, dir: fdir_r};

  // ==================================================
  // read mux
  wire [31:0] status_w = {28'h000_0000, err_r, req_r, done_r, busy_r};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        `HRS_OFF_CFG: prdata <= {27'h000_0000, dir_r, 1'b0, method_r};
        `HRS_OFF_HOME_ADDR: prdata <= home_addr_r;
        `HRS_OFF_STBY_ADDR: prdata <= stby_addr_r;
        `HRS_OFF_HR_SPEED: prdata <= {14'h0000, hr_speed_r};
        `HRS_OFF_CREEP: prdata <= {14'h0000, creep_r};
        `HRS_OFF_ACC_TIME: prdata <= {16'h0000, acc_time_r};
        `HRS_OFF_DSTOP_TIME: prdata <= {16'h0000, dstop_time_r};
        `HRS_OFF_POST_DOG: prdata <= post_dog_r;
        `HRS_OFF_DWELL: prdata <= {16'h0000, dwell_r};
        `HRS_OFF_STATUS: prdata <= status_w;
        `HRS_OFF_FEED_POS: prdata <= feed_r;
        `HRS_OFF_CUR_SPEED: prdata <= {14'h0000, speed_r};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
  wire unused_rd = rd_en;

  // ==================================================
  // checks
  a_req_after_reset: assert property (@(posedge pclk) $rose(presetn) |-> req_r)
    else $error("home request not set after reset");
  a_fast_needs_home: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && start_cmd && !busy_r && !done_r && start_type != HRS_T_MACHINE) |=> !fast_r || !busy_r)
    else $error("fast return started without home");
  a_feed_at_home: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && state_r == HRS_S_DONE && !fast_r) |=> feed_r == $past(home_addr_r))
    else $error("feed position not home address");
  a_done_clears_req: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(done_r) |-> !req_r && !busy_r)
    else $error("completion flags wrong");
  a_seek_until_dog: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && state_r == HRS_S_SEEK && !dog) |=> state_r == HRS_S_SEEK || !clk_en)
    else $error("left seek without dog");
  a_stop3_creeps: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && go_mach && method_r == HRS_M_STOP3) |=> state_r == HRS_S_CREEP)
    else $error("stopper 3 did not creep");
  a_dog_zero_stop: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && state_r == HRS_S_CREEP && method_r == HRS_M_DOG && !dogoff_r) |=> state_r != HRS_S_DONE)
    else $error("dog method stopped before dog off");
  a_acc_bound: assert property (@(posedge pclk) disable iff (!presetn)
    acc_time_r <= `HRS_MAX_MS && dstop_time_r <= `HRS_MAX_MS)
    else $error("ramp time out of range");
  a_dir_machine: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && go_mach) |=> fdir_r == $past(dir_r))
    else $error("direction not taken from setting");
  // completion paths, start flags and the freeze
  a_stop1_dwell: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && state_r == HRS_S_CREEP && method_r == HRS_M_STOP1 && !dwell_done) |=> state_r != HRS_S_DONE)
    else $error("stopper 1 stopped before dwell");
  a_cnt2_no_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && state_r == HRS_S_TRAVEL && method_r == HRS_M_CNT2 && travel_done) |=> state_r == HRS_S_DONE)
    else $error("count 2 waited after distance");
  a_busy_on_start: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && go_mach) |=> busy_r && !done_r)
    else $error("busy not raised on start");
  a_freeze_state: assert property (@(posedge pclk) disable iff (!presetn)
    !clk_en |=> state_r == $past(state_r) && feed_r == $past(feed_r))
    else $error("state moved while frozen");
endmodule : hrs_home_return_sequencer

/* File: tb/hrs_drive_model.sv */
// hrs_drive_model: axis behind the drive, with dog cam, zero marks, stopper
// assumes: one step pulse per pclk at most, dir high means increasing address
`timescale 1ns/1ps
module hrs_drive_model
  import hrs_pkg::*;
#(
  parameter int DOG_LO = 5,
  parameter int DOG_HI = 8,
  parameter int ZERO_PER = 12,
  parameter int STOP_AT = 10
)(
  // clock
  input wire logic pclk,
  // bench control
  input wire logic load,
  input wire logic stop_en,
  // axis
  input wire hrs_drive_t drive,
  output hrs_sense_t sense,
  output int pos
);
  logic stall_r = 1'h0;
  // ==================================================
  // motion: stopper swallows steps instead of moving
  always @(posedge pclk)
  begin
    if (load)
    begin
      pos <= 1;
      stall_r <= 1'h0;
    end
    else if (drive.step)
    begin
      if (stop_en && drive.dir && pos >= STOP_AT)
        stall_r <= 1'h1;
      else
        pos <= drive.dir ? pos + 1 : pos - 1;
    end
  end
  // cam window and marks; a stall also reports zero, as a torque-limited drive would
  assign sense = '{dog: (pos >= DOG_LO) && (pos <= DOG_HI), zero: (pos % ZERO_PER == 0) || stall_r};
endmodule : hrs_drive_model

/* File: tb/tb.sv */
// tb: self-checking bench for the home return sequencer
// assumes: package, params header and drive model compiled first
`timescale 1ns/1ps
`include "hrs_params.svh"
module tb;
  import hrs_pkg::*;
  typedef struct {string nm; logic [31:0] e; logic [31:0] m; logic er;} hrs_note_t;
  // ==================================================
  // signals
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic load = 1'h1;
  logic stop_en = 1'h0;
  logic clk_en = 1'h1;
  hrs_sense_t sense;
  hrs_drive_t drive;
  int pos;
  int mismatches = 0;
  int n_tests = 0;
  logic [31:0] rd;
  logic [31:0] rv;
  hrs_note_t notes[$];
  bit [5:0] stp = 6'h0E;
  int epos[6] = '{12, 10, 10, 10, 12, 10};
  localparam int CPM = 40; // shortened millisecond keeps runs brief
  // ==================================================
  // design and axis
  // pulse rates scale with the shortened millisecond, so one second is CPM*1000 cycles
  hrs_home_return_sequencer #(.CYC_PER_MS(CPM), .CLK_HZ(CPM * 1000)) i_hrs_home_return_sequencer (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sense(sense), .drive(drive));
  hrs_drive_model i_hrs_drive_model (.pclk(pclk), .load(load), .stop_en(stop_en),
    .drive(drive), .sense(sense), .pos(pos));
  // clock
  initial
  begin
    forever #12.5 pclk = ~pclk;
  end
  // ==================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      n_tests++;
      if (g !== e)
      begin
        mismatches++;
        $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
    end
  endtask : chk
  // apb transfer; waits on pready, never assumes a latency
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    begin
      n = 0;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1 && n < 50)
      begin
        n++;
        @(posedge pclk);
      end
      if (n >= 50)
        mismatches++;
      rd = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask : apb
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e,
                     input logic [31:0] m, input logic er);
    begin
      notes.push_back('{nm, e, m, er});
      apb(1'h0, a, 32'h0000_0000);
    end
  endtask : rdc
  // poll until busy drops; bounded so a stuck axis ends the wait and counts a mismatch
  task automatic wait_idle();
    int k;
    begin
      k = 0;
      rd = 32'h0000_0001;
      while (rd[`HRS_ST_BUSY] !== 1'h0 && k < 3000)
      begin
        apb(1'h0, `HRS_OFF_STATUS, 32'h0000_0000);
        k++;
      end
      if (k >= 3000)
        mismatches++;
    end
  endtask : wait_idle
  task automatic cfg_all();
    begin
      apb(1'h1, `HRS_OFF_HR_SPEED, 32'h0000_07D0);
      apb(1'h1, `HRS_OFF_CREEP, 32'h0000_0190);
      apb(1'h1, `HRS_OFF_ACC_TIME, 32'h0000_0000);
      apb(1'h1, `HRS_OFF_DSTOP_TIME, 32'h0000_0000);
      apb(1'h1, `HRS_OFF_DWELL, 32'h0000_0014);
      apb(1'h1, `HRS_OFF_HOME_ADDR, 32'h0000_0064);
    end
  endtask : cfg_all
  task automatic home(input logic [2:0] m, input logic sp, input logic [31:0] ep);
    begin
      load <= 1'h1;
      stop_en <= sp;
      apb(1'h1, `HRS_OFF_CFG, {27'h0, 1'h1, 1'h0, m});
      apb(1'h1, `HRS_OFF_POST_DOG, 32'h0000_0005);
      load <= 1'h0;
      apb(1'h1, `HRS_OFF_CTRL, 32'h0000_0001);
      rdc("busy", `HRS_OFF_STATUS, 32'h0000_0001, 32'h0000_0001, 1'h0);
      wait_idle();
      rdc("status", `HRS_OFF_STATUS, 32'h0000_0002, 32'h0000_0007, 1'h0);
      rdc("feed", `HRS_OFF_FEED_POS, 32'h0000_0064, 32'hFFFF_FFFF, 1'h0);
      chk("axis pos", ep, pos);
    end
  endtask : home
  task automatic print_verdict();
    begin
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask : print_verdict
  // ==================================================
  // monitor: oldest note against each completed read while a note is queued
  initial
  begin
    hrs_note_t n;
    forever
    begin
      @(posedge pclk);
      if (psel === 1'h1 && penable === 1'h1 && pready === 1'h1 && pwrite === 1'h0 && notes.size() > 0)
      begin
        n = notes.pop_front();
        chk(n.nm, n.e & n.m, prdata & n.m);
        chk({n.nm, " slverr"}, {31'h0, n.er}, {31'h0, pslverr});
      end
    end
  end
  // watchdog
  initial
  begin
    repeat (60000) @(posedge pclk);
    mismatches++;
    print_verdict();
  end
  // ==================================================
  // main sequence
  initial
  begin
    int k;
    void'($urandom(32'hb522));
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    rdc("req", `HRS_OFF_STATUS, 32'h0000_0004, 32'h0000_000F, 1'h0);
    $display("test reset done");
    apb(1'h1, `HRS_OFF_ACC_TIME, 32'h0000_8000);
    rdc("acc", `HRS_OFF_ACC_TIME, 32'h0000_7FFF, 32'hFFFF_FFFF, 1'h0);
    apb(1'h1, `HRS_OFF_POST_DOG, 32'hFFFF_FFFF);
    rdc("postdog", `HRS_OFF_POST_DOG, 32'h7FFF_FFFF, 32'hFFFF_FFFF, 1'h0);
    rv = $urandom();
    apb(1'h1, `HRS_OFF_HOME_ADDR, rv);
    rdc("home", `HRS_OFF_HOME_ADDR, rv, 32'hFFFF_FFFF, 1'h0);
    // a write while frozen must not land, reads still answer
    clk_en <= 1'h0;
    apb(1'h1, `HRS_OFF_HOME_ADDR, ~rv);
    rdc("frozen", `HRS_OFF_HOME_ADDR, rv, 32'hFFFF_FFFF, 1'h0);
    clk_en <= 1'h1;
    rdc("unmapped", 12'h100, 32'h0000_0000, 32'hFFFF_FFFF, 1'h1);
    apb(1'h1, `HRS_OFF_CTRL, 32'h0000_0000);
    rdc("nostart", `HRS_OFF_STATUS, 32'h0000_0004, 32'h0000_0007, 1'h0);
    $display("test registers done");
    // reverse start, then reset in mid motion
    cfg_all();
    load <= 1'h0;
    apb(1'h1, `HRS_OFF_CFG, 32'h0000_0000);
    apb(1'h1, `HRS_OFF_CTRL, 32'h0000_0001);
    k = 0;
    while (drive.step !== 1'h1 && k < 5000)
    begin
      @(posedge pclk);
      k++;
    end
    chk("dir", 32'h0, {31'h0, drive.dir});
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    rdc("req2", `HRS_OFF_STATUS, 32'h0000_0004, 32'h0000_000F, 1'h0);
    rdc("accrst", `HRS_OFF_ACC_TIME, 32'h0000_03E8, 32'hFFFF_FFFF, 1'h0);
    rdc("dstoprst", `HRS_OFF_DSTOP_TIME, 32'h0000_03E8, 32'hFFFF_FFFF, 1'h0);
    rdc("pdrst", `HRS_OFF_POST_DOG, 32'h0000_0000, 32'hFFFF_FFFF, 1'h0);
    $display("test reverse done");
    cfg_all();
    apb(1'h1, `HRS_OFF_CTRL, 32'h0000_0003);
    rdc("early fast", `HRS_OFF_STATUS, 32'h0000_000C, 32'h0000_000F, 1'h0);
    $display("test early fast done");
    for (int i = 0; i < 6; i++)
    begin
      home(3'(i), stp[i], 32'(epos[i]));
      $display("test method %0d done", i);
    end
    // fast returns ignore dog and zero, and the method setting
    apb(1'h1, `HRS_OFF_STBY_ADDR, 32'h0000_006E);
    apb(1'h1, `HRS_OFF_CTRL, 32'h0000_0005);
    wait_idle();
    chk("stby pos", 32'h0000_0014, pos);
    rdc("stby feed", `HRS_OFF_FEED_POS, 32'h0000_006E, 32'hFFFF_FFFF, 1'h0);
    apb(1'h1, `HRS_OFF_CFG, 32'h0000_0013);
    apb(1'h1, `HRS_OFF_CTRL, 32'h0000_0003);
    wait_idle();
    chk("fast pos", 32'h0000_000A, pos);
    rdc("fast feed", `HRS_OFF_FEED_POS, 32'h0000_0064, 32'hFFFF_FFFF, 1'h0);
    apb(1'h1, `HRS_OFF_CTRL, 32'h0000_0007);
    rdc("bad type", `HRS_OFF_STATUS, 32'h0000_000A, 32'h0000_000F, 1'h0);
    $display("test fast done");
    print_verdict();
  end
endmodule : tb
